// File: nvm_ctrl_pkg.sv
// constants, field layouts and carrier types for the lock, fuse and self-programming control
package nvm_ctrl_pkg;
    // control register on the cpu i/o space
    localparam logic [5:0] CSR_IO_ADDR = 6'h37;
    localparam int CSR_WIDTH = 6;
    localparam int SPM_WINDOW_CYCLES = 4;
    localparam logic [1:0] WINDOW_LAST = 2'(SPM_WINDOW_CYCLES - 1);

    // lock byte
    localparam logic [7:0] LOCK_RESET = 8'hff;
    localparam logic [7:0] LOCK_USED_MASK = 8'h03;
    localparam int LOCK_LOW_BIT = 0;
    localparam int LOCK_HIGH_BIT = 1;

    // fuse byte defaults, one means unprogrammed
    localparam logic [7:0] FUSE_EXT_DEFAULT = 8'hff;
    localparam logic [7:0] FUSE_HIGH_DEFAULT = 8'hdf;
    localparam logic [7:0] FUSE_LOW_DEFAULT = 8'h62;
    localparam logic [7:0] FUSE_EXT_USED_MASK = 8'h01;
    localparam logic [7:0] NO_KEEP_MASK = 8'h00;

    // fuse field positions
    localparam int EXT_SELF_PROG_BIT = 0;
    localparam int HIGH_RESET_DIS_BIT = 7;
    localparam int HIGH_DEBUG_LINK_BIT = 6;
    localparam int HIGH_SERIAL_PROG_BIT = 5;
    localparam int HIGH_WDT_FORCED_BIT = 4;
    localparam int HIGH_EEPROM_KEEP_BIT = 3;
    localparam int HIGH_BROWNOUT_LSB = 0;
    localparam int HIGH_BROWNOUT_W = 3;
    localparam int LOW_PRESCALE_BIT = 7;
    localparam int LOW_CLOCK_OUT_BIT = 6;
    localparam int LOW_STARTUP_LSB = 4;
    localparam int LOW_STARTUP_W = 2;
    localparam int LOW_CLOCK_SRC_LSB = 0;
    localparam int LOW_CLOCK_SRC_W = 4;
    localparam logic [7:0] HIGH_SERIAL_KEEP_MASK = 8'h20;

    // flash address pointer selection for a fuse/lock read
    localparam logic [1:0] ZSEL_FUSE_LOW = 2'h0;
    localparam logic [1:0] ZSEL_LOCK = 2'h1;
    localparam logic [1:0] ZSEL_FUSE_EXT = 2'h2;
    localparam logic [1:0] ZSEL_FUSE_HIGH = 2'h3;

    // programmer fuse byte select
    localparam logic [1:0] FSEL_LOW = 2'h0;
    localparam logic [1:0] FSEL_HIGH = 2'h1;
    localparam logic [1:0] FSEL_EXT = 2'h2;

    // signature table lies outside this block; value is arbitrary
    localparam logic [7:0] SIG_FILL = 8'hff;

    typedef struct packed {
        logic sig;
        logic buffer_clear_bit;
        logic fuse_lock_read_bit;
        logic page_write_bit;
        logic page_erase_bit;
        logic spmen;
    } csr_t;

    typedef struct packed {
        logic [7:0] ext;
        logic [7:0] high;
        logic [7:0] low;
    } fuse_set_t;

    typedef struct packed {
        logic fuse_we;
        logic [1:0] fuse_sel;
        logic [7:0] fuse_data;
        logic lock_we;
        logic [7:0] lock_data;
        logic chip_erase;
    } prog_req_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PAGE_BUSY} spm_state_t;
endpackage

// File: fuse_byte_cell.sv
// one fuse byte: stored value plus the copy latched for use by the chip
`timescale 1ns/100ps
module fuse_byte_cell #(
    parameter logic [7:0] DEFAULT = 8'hff
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] keep_mask_i,
    input wire logic latch_i,
    output logic [7:0] nv_o,
    output logic [7:0] latched_o
);
    logic [7:0] nv_q;
    logic [7:0] nv_d;
    logic [7:0] lat_q;
    logic [7:0] lat_d;

    // bits under the keep mask cannot be changed by this write
    assign nv_d = we_i ? ((wdata_i & ~keep_mask_i) | (nv_q & keep_mask_i)) : nv_q;
    assign lat_d = latch_i ? nv_q : lat_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            nv_q <= DEFAULT;
            lat_q <= DEFAULT;
        end else begin
            nv_q <= nv_d;
            lat_q <= lat_d;
        end
    end

    assign nv_o = nv_q;
    assign latched_o = lat_q;
endmodule

// File: lock_fuse_selfprog_control.sv
// self-programming control register, lock bits and fuse bytes with their protection
`timescale 1ns/100ps
// Functional notes
// R1: a store-enable write opens a store window of exactly four clock cycles
// R2: enable plus a special bit makes the next load/store do that special operation
// R3: enable alone makes the next store write the register pair into the page buffer
// R4: buffer fill ignores pointer bit zero, addressing whole words
// R5: store-enable clears after a store completes or after four idle cycles
// R6: store-enable stays set until a page erase or page write finishes
// R7: lock bits sit in bits 1:0, zero is programmed, other bits read one
// R8: only chip erase returns lock bits to one
// R9: stores allowed across the whole program memory only when self-program fuse programmed
// R10: programmed debug-link fuse allows readout regardless of lock bits
// R11: mode 2 refuses programming, locks fuses, disables the debug link
// R12: mode 3 refuses programming and verify, locks fuses, disables the debug link
// R13: three fuse bytes, programmed fuses read as zero
// R14: extended bit 0 is the self-program enable, other extended bits read one
// R15: high byte layout: reset-disable, debug, serial-prog, watchdog, eeprom-keep, brownout
// R16: serial-programming fuse cannot change in serial programming mode
// R17: programmed watchdog forced fuse disables the watchdog interrupt
// R18: low byte layout: prescale, clock out, start-up, clock source
// R19: with reset pin disabled only high-voltage mode may program
// R20: programmed low lock bit makes fuses unchangeable
// R21: chip erase leaves every fuse unchanged
// R22: fuses latch at power-up and programming mode changes; eeprom-keep and self-program enable act live
// R23: each new store-enable write restarts the window counter from zero; a write made during a page operation is ignored
module lock_fuse_selfprog_control
    import nvm_ctrl_pkg::*;
(
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [5:0] IO_ADDR_I,
    input wire logic IO_WE_I,
    input wire logic IO_RE_I,
    input wire logic [7:0] IO_WDATA_I,
    output logic [7:0] IO_RDATA_O,
    input wire logic SPM_I,
    input wire logic LPM_I,
    input wire logic [15:0] Z_I,
    input wire logic [15:0] R_PAIR_I,
    input wire logic NVM_DONE_I,
    output logic BUF_WE_O,
    output logic [14:0] BUF_WADDR_O,
    output logic [15:0] BUF_WDATA_O,
    output logic BUF_CLEAR_O,
    output logic PAGE_ERASE_O,
    output logic PAGE_WRITE_O,
    output logic [14:0] PAGE_ADDR_O,
    output logic CPU_HALT_O,
    output logic LPM_SPECIAL_O,
    output logic [7:0] LPM_DATA_O,
    input wire logic PROG_MODE_I,
    input wire logic PROG_HV_I,
    input wire prog_req_t PROG_REQ_I,
    output logic PROG_REFUSED_O,
    output logic PROG_MEM_WR_OK_O,
    output logic PROG_MEM_RD_OK_O,
    output logic [7:0] LOCK_O,
    output fuse_set_t FUSES_O,
    output logic SELF_PROG_EN_O,
    output logic DEBUG_READOUT_O,
    output logic DEBUG_LINK_EN_O,
    output logic RESET_PIN_EN_O,
    output logic WDT_IRQ_DIS_O,
    output logic EEPROM_KEEP_O,
    output logic [2:0] BROWNOUT_LEVEL_O,
    output logic CLOCK_DIV8_O,
    output logic CLOCK_OUT_EN_O,
    output logic [1:0] STARTUP_TIME_O,
    output logic [3:0] CLOCK_SOURCE_O
);
    spm_state_t state_q;
    spm_state_t state_d;
    csr_t csr_q;
    csr_t csr_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic [7:0] lock_q;
    logic [7:0] lock_d;
    logic boot_done_q;
    logic pm_q;
    logic buf_we_q;
    logic buf_clr_q;
    logic erase_q;
    logic write_q;
    logic [14:0] waddr_q;
    logic [15:0] wdata_q;
    logic lpm_sp_q;
    logic [7:0] lpm_data_q;
    logic [7:0] rdata_q;
    logic refused_q;
    fuse_set_t nv;
    fuse_set_t lat;

    // cpu side decode
    wire csr_hit = IO_ADDR_I == CSR_IO_ADDR;
    wire csr_t csr_wr = csr_t'(IO_WDATA_I[CSR_WIDTH-1:0]);
    wire csr_arm = IO_WE_I && csr_hit && csr_wr.spmen && state_q != ST_PAGE_BUSY;
    wire self_prog_en = !nv.ext[EXT_SELF_PROG_BIT]; // R9 R14
    wire armed = state_q == ST_ARMED;
    wire spm_go = armed && !csr_arm && SPM_I && self_prog_en; // R1 R9
    wire lpm_go = armed && !csr_arm && !spm_go && LPM_I && (csr_q.fuse_lock_read_bit || csr_q.sig); // R2
    wire page_op = csr_q.page_erase_bit || csr_q.page_write_bit;
    wire fill_go = spm_go && !page_op && !csr_q.buffer_clear_bit && !csr_q.fuse_lock_read_bit && !csr_q.sig; // R3
    wire clear_go = spm_go && !page_op && csr_q.buffer_clear_bit; // R2
    wire expire = armed && !csr_arm && !spm_go && !lpm_go && cnt_q == WINDOW_LAST; // R5

    // lock state and protection modes
    wire lock_low_prog = !lock_q[LOCK_LOW_BIT];
    wire lock_high_prog = !lock_q[LOCK_HIGH_BIT];
    wire mode1 = !lock_low_prog && !lock_high_prog;
    wire mode3 = lock_low_prog && lock_high_prog;
    // reset pin disabled leaves only the high-voltage path open
    wire path_ok = PROG_MODE_I && (PROG_HV_I || lat.high[HIGH_RESET_DIS_BIT]); // R19
    wire erase_go = path_ok && PROG_REQ_I.chip_erase;
    wire fuse_req = PROG_MODE_I && PROG_REQ_I.fuse_we;
    // fuses lock once the low lock bit is programmed; chip erase never touches them
    wire fuse_ok = path_ok && PROG_REQ_I.fuse_we && !lock_low_prog && !erase_go; // R20 R11 R12 R21
    wire lock_ok = path_ok && PROG_REQ_I.lock_we && !erase_go;
    wire [7:0] high_keep = PROG_HV_I ? NO_KEEP_MASK : HIGH_SERIAL_KEEP_MASK; // R16
    wire fuse_low_we = fuse_ok && PROG_REQ_I.fuse_sel == FSEL_LOW;
    wire fuse_high_we = fuse_ok && PROG_REQ_I.fuse_sel == FSEL_HIGH;
    wire fuse_ext_we = fuse_ok && PROG_REQ_I.fuse_sel == FSEL_EXT;
    // fuses take effect on power-up and on every programming mode change
    wire fuse_latch = !boot_done_q || (PROG_MODE_I != pm_q); // R22

    wire [7:0] lock_rd = lock_q | ~LOCK_USED_MASK; // R7
    wire [7:0] ext_rd = nv.ext | ~FUSE_EXT_USED_MASK; // R14
    wire [7:0] fuse_lock_rd = (Z_I[1:0] == ZSEL_FUSE_LOW) ? nv.low :
                              (Z_I[1:0] == ZSEL_LOCK) ? lock_rd :
                              (Z_I[1:0] == ZSEL_FUSE_EXT) ? ext_rd : nv.high; // R13
    wire [7:0] lpm_rd = csr_q.fuse_lock_read_bit ? fuse_lock_rd : SIG_FILL;

    fuse_byte_cell #(.DEFAULT(FUSE_LOW_DEFAULT)) u_fuse_low (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .we_i(fuse_low_we),
        .wdata_i(PROG_REQ_I.fuse_data),
        .keep_mask_i(NO_KEEP_MASK),
        .latch_i(fuse_latch),
        .nv_o(nv.low),
        .latched_o(lat.low)
    );
    fuse_byte_cell #(.DEFAULT(FUSE_HIGH_DEFAULT)) u_fuse_high (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .we_i(fuse_high_we),
        .wdata_i(PROG_REQ_I.fuse_data),
        .keep_mask_i(high_keep),
        .latch_i(fuse_latch),
        .nv_o(nv.high),
        .latched_o(lat.high)
    );
    fuse_byte_cell #(.DEFAULT(FUSE_EXT_DEFAULT)) u_fuse_ext (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .we_i(fuse_ext_we),
        .wdata_i(PROG_REQ_I.fuse_data),
        .keep_mask_i(NO_KEEP_MASK),
        .latch_i(fuse_latch),
        .nv_o(nv.ext),
        .latched_o(lat.ext)
    );

    // lock bits can only be programmed; erase is the sole way back to one
    assign lock_d = erase_go ? LOCK_RESET : lock_ok ? (lock_q & PROG_REQ_I.lock_data) : lock_q; // R8

    always_comb begin
        state_d = state_q;
        csr_d = csr_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE, ST_ARMED: begin
                if (csr_arm) begin
                    state_d = ST_ARMED;
                    csr_d = csr_wr;
                    cnt_d = '0; // R23
                end else if (spm_go && page_op) begin
                    state_d = ST_PAGE_BUSY; // R6
                end else if (spm_go || lpm_go || expire) begin
                    state_d = ST_IDLE; // R5
                    csr_d = '0;
                end else if (armed) begin
                    cnt_d = cnt_q + 2'h1; // R1
                end
            end
            ST_PAGE_BUSY: begin
                // enable stays up while the flash works
                if (NVM_DONE_I) begin
                    state_d = ST_IDLE; // R6
                    csr_d = '0;
                end
            end
            default: begin
                state_d = ST_IDLE;
                csr_d = '0;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_q <= ST_IDLE;
            csr_q <= '0;
            cnt_q <= '0;
            lock_q <= LOCK_RESET;
            boot_done_q <= 1'b0;
            pm_q <= 1'b0;
        end else begin
            state_q <= state_d;
            csr_q <= csr_d;
            cnt_q <= cnt_d;
            lock_q <= lock_d;
            boot_done_q <= 1'b1;
            pm_q <= PROG_MODE_I;
        end
    end

    // action pulses and their data, registered one cycle after the instruction
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            buf_we_q <= 1'b0;
            buf_clr_q <= 1'b0;
            erase_q <= 1'b0;
            write_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            lpm_sp_q <= 1'b0;
            lpm_data_q <= '0;
            rdata_q <= '0;
            refused_q <= 1'b0;
        end else begin
            buf_we_q <= fill_go; // R3
            buf_clr_q <= clear_go;
            erase_q <= spm_go && csr_q.page_erase_bit && !csr_q.page_write_bit;
            write_q <= spm_go && csr_q.page_write_bit;
            waddr_q <= spm_go ? Z_I[15:1] : waddr_q; // R4
            wdata_q <= fill_go ? R_PAIR_I : wdata_q;
            lpm_sp_q <= lpm_go;
            lpm_data_q <= lpm_go ? lpm_rd : lpm_data_q;
            rdata_q <= (IO_RE_I && csr_hit) ? {2'h0, csr_q} : 8'h00;
            refused_q <= fuse_req && !fuse_ok;
        end
    end

    assign IO_RDATA_O = rdata_q;
    assign BUF_WE_O = buf_we_q;
    assign BUF_WADDR_O = waddr_q;
    assign BUF_WDATA_O = wdata_q;
    assign BUF_CLEAR_O = buf_clr_q;
    assign PAGE_ERASE_O = erase_q;
    assign PAGE_WRITE_O = write_q;
    assign PAGE_ADDR_O = waddr_q;
    assign CPU_HALT_O = state_q == ST_PAGE_BUSY;
    assign LPM_SPECIAL_O = lpm_sp_q;
    assign LPM_DATA_O = lpm_data_q;
    assign PROG_REFUSED_O = refused_q;
    assign PROG_MEM_WR_OK_O = path_ok && mode1; // R11 R12
    assign PROG_MEM_RD_OK_O = path_ok && !mode3; // R12
    assign LOCK_O = lock_rd;
    assign FUSES_O = '{ext: lat.ext | ~FUSE_EXT_USED_MASK, high: lat.high, low: lat.low};
    assign SELF_PROG_EN_O = self_prog_en;
    // readout through the debug link ignores the lock bits entirely
    assign DEBUG_READOUT_O = !lat.high[HIGH_DEBUG_LINK_BIT]; // R10
    assign DEBUG_LINK_EN_O = !lat.high[HIGH_DEBUG_LINK_BIT] && mode1; // R11 R12
    assign RESET_PIN_EN_O = lat.high[HIGH_RESET_DIS_BIT]; // R15
    assign WDT_IRQ_DIS_O = !lat.high[HIGH_WDT_FORCED_BIT]; // R17
    assign EEPROM_KEEP_O = !nv.high[HIGH_EEPROM_KEEP_BIT]; // R22
    assign BROWNOUT_LEVEL_O = lat.high[HIGH_BROWNOUT_LSB +: HIGH_BROWNOUT_W]; // R15
    assign CLOCK_DIV8_O = !lat.low[LOW_PRESCALE_BIT]; // R18
    assign CLOCK_OUT_EN_O = !lat.low[LOW_CLOCK_OUT_BIT]; // R18
    assign STARTUP_TIME_O = lat.low[LOW_STARTUP_LSB +: LOW_STARTUP_W]; // R18
    assign CLOCK_SOURCE_O = lat.low[LOW_CLOCK_SRC_LSB +: LOW_CLOCK_SRC_W]; // R18

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    // store window
    a_window_closes_four: assert property (csr_arm ##1 (!SPM_I && !LPM_I && !IO_WE_I)[*4] // R1 R5
        |=> !csr_q.spmen && state_q == ST_IDLE) else $error("store window outlived four cycles");
    a_window_open_four: assert property (csr_arm ##1 (!SPM_I && !LPM_I && !IO_WE_I)[*3] // R1
        |-> csr_q.spmen && armed) else $error("store window closed early");
    a_restart_window: assert property (csr_arm |=> cnt_q == 2'h0) else $error("window not restarted"); // R23
    a_fill_word_addr: assert property (fill_go |=> BUF_WE_O && BUF_WADDR_O == $past(Z_I[15:1]) // R3 R4
        && BUF_WDATA_O == $past(R_PAIR_I)) else $error("buffer fill address or data wrong");
    a_fill_one_pulse: assert property (BUF_WE_O |=> !BUF_WE_O && !csr_q.spmen) else $error("fill not single"); // R5
    a_busy_keeps_en: assert property (state_q == ST_PAGE_BUSY |-> csr_q.spmen && CPU_HALT_O) // R6
        else $error("enable dropped during page operation");
    a_store_needs_fuse: assert property ((BUF_WE_O || PAGE_ERASE_O || PAGE_WRITE_O) |-> $past(self_prog_en)) // R9
        else $error("store without self-program fuse");

    // lock and fuse protection
    a_lock_only_erase: assert property ((lock_q & ~$past(lock_q)) != 8'h00 |-> $past(erase_go)) // R8
        else $error("lock bit erased without chip erase");
    a_lock_high_one: assert property (LOCK_O[7:2] == 6'h3f) else $error("unused lock bits not one"); // R7
    a_fuses_locked: assert property (lock_low_prog |=> $stable(nv)) else $error("fuse changed while locked"); // R20
    a_erase_keeps_fuse: assert property (erase_go |=> $stable(nv)) else $error("chip erase changed a fuse"); // R21
    a_serial_fuse_kept: assert property (PROG_MODE_I && !PROG_HV_I // R16
        |=> $stable(nv.high[HIGH_SERIAL_PROG_BIT])) else $error("serial fuse changed in serial mode");
    a_mode3_no_verify: assert property (mode3 |-> !PROG_MEM_RD_OK_O && !PROG_MEM_WR_OK_O && !DEBUG_LINK_EN_O) // R12
        else $error("mode 3 protection missing");
    a_mode2_no_write: assert property (lock_low_prog && !lock_high_prog // R11
        |-> !PROG_MEM_WR_OK_O && !DEBUG_LINK_EN_O)
        else $error("mode 2 protection missing");
    a_latch_held: assert property (PROG_MODE_I && $past(PROG_MODE_I) && boot_done_q |=> $stable(lat)) // R22
        else $error("fuse took effect inside programming mode");
    a_refused_pulse: assert property (fuse_req && !fuse_ok |=> PROG_REFUSED_O) // R20
        else $error("refused fuse write not flagged");
    a_erase_unlocks: assert property (erase_go |=> LOCK_O == LOCK_RESET) // R8
        else $error("chip erase left locks");
    a_debug_gated: assert property (DEBUG_LINK_EN_O // R10 R11
        |-> DEBUG_READOUT_O && mode1)
        else $error("debug link open under lock");

    // page operations and special results
    a_page_halts: assert property ((PAGE_ERASE_O || PAGE_WRITE_O) |-> CPU_HALT_O) // R6
        else $error("page start without halt");
    a_busy_release: assert property (state_q == ST_PAGE_BUSY && NVM_DONE_I // R5 R6
        |=> state_q == ST_IDLE && !csr_q.spmen)
        else $error("enable held after page done");
    a_clear_pulse: assert property (clear_go |=> BUF_CLEAR_O && !BUF_WE_O) // R2
        else $error("buffer clear missing");
    a_special_read: assert property (lpm_go // R2
        |=> LPM_SPECIAL_O && LPM_DATA_O == $past(lpm_rd))
        else $error("special load result wrong");
    a_no_action_idle: assert property (!armed // R1
        |=> !LPM_SPECIAL_O && !BUF_WE_O && !BUF_CLEAR_O)
        else $error("action outside store window");
    a_ext_unused_one: assert property (FUSES_O.ext[7:1] == 7'h7f) // R14
        else $error("unused extended fuses not one");

    // main scenarios
    c_buffer_fill: cover property (csr_arm ##[1:4] BUF_WE_O);
    c_page_write: cover property (PAGE_WRITE_O ##[1:20] (state_q == ST_IDLE));
    c_page_erase: cover property (PAGE_ERASE_O ##[1:60] (state_q == ST_IDLE));
    c_fuse_read: cover property (LPM_SPECIAL_O && csr_q == '0);
    c_fuse_refused: cover property (PROG_REFUSED_O);
endmodule

// File: nvm_array_model.sv
// behavioural page erase and page write engine facing the control block
`timescale 1ns/100ps
module nvm_array_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic [7:0] delay_i,
    output logic done_o
);
    logic [7:0] cnt_q;
    logic busy_q;
    // delay sampled at start, so the bench can make each operation quick or slow
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 8'h00;
            busy_q <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= busy_q && cnt_q == 8'h00;
            if (start_i) begin
                busy_q <= 1'b1;
                cnt_q <= delay_i;
            end else if (busy_q) begin
                if (cnt_q == 8'h00) busy_q <= 1'b0;
                else cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

// File: tb.sv
// self-checking testbench for the lock, fuse and self-programming control
`timescale 1ns/100ps
module tb
    import nvm_ctrl_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, io_we = 1'b0, io_re = 1'b0, store_program_instr = 1'b0, lpm = 1'b0, pm = 1'b0, phv = 1'b0;
    logic done, buf_we, buf_clr, pg_ers, pg_wr, halt, lpm_sp, refused, wr_ok, rd_ok, r;
    logic sp_en, dbg_rd, dbg_en, rst_en, wdt_dis, ee_keep, div8, ck_out;
    logic [5:0] addr = 6'h00;
    logic [7:0] wd = 8'h00, dly = 8'h0c, rd, lock, lpm_d;
    logic [7:0] rdx [4] = '{8'h62, 8'hff, 8'hfe, 8'h87};
    logic [14:0] baddr, paddr;
    logic [15:0] z = 16'h0000, rp = 16'h0000, bdata;
    logic [2:0] bod;
    logic [1:0] startup_time_fuses;
    logic [3:0] cksrc;
    prog_req_t req = '0;
    fuse_set_t fuses;
    int err_count = 0, num_checks = 0, n;

    lock_fuse_selfprog_control i_lock_fuse_selfprog_control (
        .CLK_I(clk), .NRST_I(nrst), .IO_ADDR_I(addr), .IO_WE_I(io_we), .IO_RE_I(io_re), .IO_WDATA_I(wd),
        .IO_RDATA_O(rd), .SPM_I(store_program_instr), .LPM_I(lpm), .Z_I(z), .R_PAIR_I(rp), .NVM_DONE_I(done),
        .BUF_WE_O(buf_we), .BUF_WADDR_O(baddr), .BUF_WDATA_O(bdata), .BUF_CLEAR_O(buf_clr),
        .PAGE_ERASE_O(pg_ers), .PAGE_WRITE_O(pg_wr), .PAGE_ADDR_O(paddr), .CPU_HALT_O(halt),
        .LPM_SPECIAL_O(lpm_sp), .LPM_DATA_O(lpm_d), .PROG_MODE_I(pm), .PROG_HV_I(phv), .PROG_REQ_I(req),
        .PROG_REFUSED_O(refused), .PROG_MEM_WR_OK_O(wr_ok), .PROG_MEM_RD_OK_O(rd_ok), .LOCK_O(lock),
        .FUSES_O(fuses), .SELF_PROG_EN_O(sp_en), .DEBUG_READOUT_O(dbg_rd), .DEBUG_LINK_EN_O(dbg_en),
        .RESET_PIN_EN_O(rst_en), .WDT_IRQ_DIS_O(wdt_dis), .EEPROM_KEEP_O(ee_keep), .BROWNOUT_LEVEL_O(bod),
        .CLOCK_DIV8_O(div8), .CLOCK_OUT_EN_O(ck_out), .STARTUP_TIME_O(startup_time_fuses), .CLOCK_SOURCE_O(cksrc)
    );
    nvm_array_model i_nvm_array_model (.clk_i(clk), .nrst_i(nrst), .start_i(pg_ers | pg_wr), .delay_i(dly),
        .done_o(done));

    always #4 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic io_wr(input logic [7:0] d);
        @(posedge clk);
        io_we <= 1'b1;
        addr <= CSR_IO_ADDR;
        wd <= d;
        @(posedge clk);
        io_we <= 1'b0;
    endtask
    task automatic io_rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        io_re <= 1'b1;
        addr <= a;
        @(posedge clk);
        io_re <= 1'b0;
        @(negedge clk);
        chk("control read", 32'(e), 32'(rd));
    endtask
    // d counts extra edges after the arming edge; 0 means the first cycle of the window
    task automatic op(input logic s, input logic l, input logic [15:0] za, input logic [15:0] rv, input int d);
        repeat (d) @(posedge clk);
        store_program_instr <= s;
        lpm <= l;
        z <= za;
        rp <= rv;
        @(posedge clk);
        store_program_instr <= 1'b0;
        lpm <= 1'b0;
        @(negedge clk);
    endtask
    // refusal pulse lands one cycle after the request; the following cycle is watched as well
    task automatic prog(input logic fw, input logic [1:0] fs, input logic [7:0] fd, input logic lw,
                        input logic [7:0] ld, input logic ce);
        @(posedge clk);
        req <= '{fw, fs, fd, lw, ld, ce};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        r = refused;
        @(negedge clk);
        r = r | refused;
    endtask
    task automatic mode(input logic m, input logic hv);
        @(posedge clk);
        pm <= m;
        phv <= hv;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #50000;
        err_count++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("lock byte", 32'hff, 32'(lock));
        chk("fuse bytes", 32'hffdf62, 32'(fuses));
        chk("self prog en", 32'h0, 32'(sp_en));
        chk("low decode", 32'ha2, 32'({div8, ck_out, startup_time_fuses, cksrc}));
        chk("high decode", 32'h47, 32'({rst_en, dbg_rd, wdt_dis, ee_keep, bod}));
        io_rd(CSR_IO_ADDR, 8'h00);
        io_rd(6'h00, 8'h00);
        io_wr(8'h01);
        op(1'b1, 1'b0, 16'h0002, 16'h1111, 0);
        chk("fill without fuse", 32'h0, 32'(buf_we));
        $display("test reset_values finished");

        mode(1'b1, 1'b0);
        prog(1'b1, FSEL_EXT, 8'hfe, 1'b0, 8'hff, 1'b0);
        chk("live self prog", 32'h1, 32'(sp_en));
        prog(1'b1, FSEL_HIGH, 8'ha7, 1'b0, 8'hff, 1'b0);
        chk("live eeprom keep", 32'h1, 32'(ee_keep));
        chk("fuses held", 32'hffdf62, 32'(fuses));
        mode(1'b0, 1'b0);
        chk("fuses latched", 32'hfe8762, 32'(fuses));
        chk("high decode", 32'h7f, 32'({rst_en, dbg_rd, wdt_dis, ee_keep, bod}));
        chk("debug link", 32'h1, 32'(dbg_en));
        $display("test fuse_write finished");

        io_wr(8'h01);
        op(1'b1, 1'b0, 16'h1235, 16'hbeef, 3);
        chk("fill strobe", 32'h1, 32'(buf_we));
        chk("fill addr", 32'h091a, 32'(baddr));
        chk("fill data", 32'hbeef, 32'(bdata));
        io_rd(CSR_IO_ADDR, 8'h00);
        io_wr(8'h01);
        op(1'b1, 1'b0, 16'h0004, 16'h2222, 4);
        chk("late store", 32'h0, 32'(buf_we));
        io_wr(8'h01);
        io_wr(8'h01);
        op(1'b1, 1'b0, 16'h0004, 16'h3333, 3);
        chk("rearmed store", 32'h1, 32'(buf_we));
        $display("test store_window finished");

        io_wr(8'h11);
        op(1'b1, 1'b0, 16'h0000, 16'h0000, 0);
        chk("buffer clear", 32'h1, 32'(buf_clr));
        io_wr(8'h21);
        op(1'b0, 1'b1, 16'h0000, 16'h0000, 0);
        chk("signature read", 32'({1'b1, SIG_FILL}), 32'({lpm_sp, lpm_d}));
        for (n = 0; n < 4; n++) begin
            io_wr(8'h09);
            op(1'b0, 1'b1, 16'(n), 16'h0000, 0);
            chk("fuse lock read", 32'({1'b1, rdx[n]}), 32'({lpm_sp, lpm_d}));
        end
        // write is prompt, erase is slow, so both halt lengths are seen
        for (n = 0; n < 2; n++) begin
            dly <= (n == 1) ? 8'h28 : 8'h0c;
            io_wr((n == 1) ? 8'h03 : 8'h05);
            op(1'b1, 1'b0, 16'h0241, 16'h0000, 0);
            chk("page start", (n == 1) ? 32'h2 : 32'h1, 32'({pg_ers, pg_wr}));
            chk("cpu halted", 32'h1, 32'(halt));
            chk("page addr", 32'h0120, 32'(paddr));
            io_wr(8'h01);
            io_rd(CSR_IO_ADDR, (n == 1) ? 8'h03 : 8'h05);
            repeat (100) if (halt === 1'b1) @(negedge clk);
            chk("halt released", 32'h0, 32'(halt));
            io_rd(CSR_IO_ADDR, 8'h00);
        end
        $display("test special_ops finished");

        mode(1'b1, 1'b1);
        chk("mode 1 access", 32'h3, 32'({wr_ok, rd_ok}));
        prog(1'b0, FSEL_LOW, 8'h00, 1'b1, 8'hfe, 1'b0);
        chk("lock mode 2", 32'hfe6, 32'({lock, wr_ok, rd_ok, dbg_rd, dbg_en}));
        prog(1'b1, FSEL_LOW, 8'h00, 1'b0, 8'hff, 1'b0);
        chk("fuse write locked", 32'h1, 32'(r));
        prog(1'b0, FSEL_LOW, 8'h00, 1'b1, 8'hff, 1'b0);
        chk("lock not raised", 32'hfe, 32'(lock));
        prog(1'b0, FSEL_LOW, 8'h00, 1'b1, 8'hfc, 1'b0);
        chk("lock mode 3", 32'h3f0, 32'({lock, wr_ok, rd_ok}));
        prog(1'b0, FSEL_LOW, 8'h00, 1'b0, 8'hff, 1'b1);
        chk("chip erase", 32'h3ff, 32'({lock, wr_ok, rd_ok}));
        mode(1'b0, 1'b0);
        chk("fuses kept", 32'hfe8762, 32'(fuses));
        $display("test lock_modes finished");

        mode(1'b1, 1'b1);
        prog(1'b1, FSEL_HIGH, 8'h07, 1'b0, 8'hff, 1'b0);
        chk("hv fuse write", 32'h0, 32'(r));
        mode(1'b0, 1'b0);
        chk("reset pin", 32'h0, 32'(rst_en));
        mode(1'b1, 1'b0);
        prog(1'b1, FSEL_LOW, 8'h00, 1'b0, 8'hff, 1'b0);
        chk("serial refused", 32'h1, 32'(r));
        mode(1'b0, 1'b1);
        mode(1'b1, 1'b1);
        prog(1'b1, FSEL_LOW, 8'h22, 1'b0, 8'hff, 1'b0);
        chk("hv accepted", 32'h0, 32'(r));
        $display("test reset_disable finished");
        test_done();
    end
endmodule
